// ===== logic/ext_ops_map.svh
// offsets, field values and constants for the extended operation decoder
// assumes inclusion by the decoder only
`ifndef EXT_OPS_MAP_SVH
`define EXT_OPS_MAP_SVH
`define OPC_PTR_ADD_HI 8'hE8
`define OPC_MOVE_HI 8'hEB
`define OPC_CALL_W 16'h0014
`define OPC_SECOND_NIBBLE 4'hF
`define PTR_SEL_RETURN 2'h3
`define PTR_RESET 12'h000
`define PC_RESET 21'h0_0000
`define PC_STEP 21'h0_0002
`define INDIRECT_READ_VALUE 8'h00
`endif

// ===== logic/ext_ops_pkg.sv
// types shared by the extended operation decoder
// assumes a four-phase instruction cycle supplied by the core
package ext_ops_pkg;
    typedef enum logic [1:0] {
        st_decode,
        st_return_nop,
        st_call_nop,
        st_move_second
    } exec_state_e;
    typedef logic [11:0] data_addr_t;
endpackage : ext_ops_pkg

// ===== logic/extended_pointer_call_move_ops.sv
// decode and execute for four extended core operations
// assumes the core gives one instruction word per cycle with a phase-four strobe,
// and that the extension enable bit is a static configuration level
// Behaviour
// [RULE1] upper byte E8h is pointer add; select 11 means add-and-return on pointer 2
// [RULE2] add unsigned 6-bit literal to the full selected pointer and write back
// [RULE3] add-and-return then loads pc from stack top and pops it
// [RULE4] add-and-return takes two cycles, second is a no-operation
// [RULE5] word 0014h decodes as call through working register
// [RULE6] call pushes pc plus 2 onto the return stack first
// [RULE7] pc low from working register, high and upper from their latches
// [RULE8] call takes two cycles, second is a no-operation
// [RULE9] call never alters working register, status flags or bank select
// [RULE10] move is two words: EBh with bit7 clear, then F in top nibble
// [RULE11] move source address is pointer 2 plus unsigned 7-bit offset
// [RULE12] move destination is the 12-bit field of the second word
// [RULE13] both move addresses span the whole 000h to FFFh space
// [RULE14] software must not target pc low or stack top bytes with move
// [RULE15] move source on an indirect register reads as 00h
// [RULE16] extended operations decode only when extension enable is set
// [RULE17] no operation here alters any arithmetic status flag
// [RULE18] move reads in phase four of cycle one, writes in phase four of cycle two
module extended_pointer_call_move_ops (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic extension_enable_bit,
    input wire logic phase4,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] pc,
    input wire logic [7:0] working_register,
    input wire logic [7:0] pc_high_latch,
    input wire logic [4:0] pc_upper_latch,
    input wire logic [20:0] return_stack_top,
    input wire logic [7:0] data_rd,
    input wire logic src_is_indirect,
    output logic [11:0] pointer_register0,
    output logic [11:0] pointer_register1,
    output logic [11:0] stack_frame_pointer,
    output logic pc_load,
    output logic [20:0] pc_load_value,
    output logic stack_push,
    output logic [20:0] stack_push_value,
    output logic stack_pop,
    output logic data_rd_en,
    output logic data_wr_en,
    output logic [11:0] data_addr,
    output logic [7:0] data_wr,
    output logic force_nop,
    output logic status_write_block
);
    import ext_ops_pkg::*;
    `include "ext_ops_map.svh"

    // one packed record holds every register of the block
    typedef struct packed {
        exec_state_e st;
        logic [11:0] ptr0;
        logic [11:0] ptr1;
        logic [11:0] ptr2;
        logic [7:0] move_byte;
        logic rd_wait;
        logic pc_load;
        logic [20:0] pc_val;
        logic push;
        logic [20:0] push_val;
        logic pop;
        logic rd_en;
        logic wr_en;
        logic [11:0] addr;
        logic [7:0] wr_data;
        logic nop;
    } core_s;

    // kind of word seen in the decode state
    typedef enum logic [2:0] {
        op_none,
        op_add,
        op_ret,
        op_call,
        op_move
    } op_kind_e;

    core_s r;
    core_s next_r;

    op_kind_e op;
    logic is_ptr_add;
    logic is_call;
    logic is_move;
    logic is_second;
    logic take_ret;
    logic [1:0] sel;
    logic [5:0] lit6;
    logic [6:0] off7;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic [20:0] call_ret_addr;
    logic [20:0] call_target;
    logic [11:0] ptr_now [0:2];
    logic [11:0] ptr_sum [0:2];
    logic [2:0] ptr_hit;

    // decode gated by the enable; disabled means these words fall to the core
    assign is_ptr_add = extension_enable_bit && instr_word[15:8] == `OPC_PTR_ADD_HI; // [RULE1] [RULE16]
    assign is_call = extension_enable_bit && instr_word == `OPC_CALL_W; // [RULE5] [RULE16]
    assign is_move = extension_enable_bit && instr_word[15:8] == `OPC_MOVE_HI && !instr_word[7]; // [RULE10] [RULE16]
    assign is_second = instr_word[15:12] == `OPC_SECOND_NIBBLE; // [RULE10]
    assign sel = instr_word[7:6];
    assign lit6 = instr_word[5:0];
    assign off7 = instr_word[6:0];
    assign take_ret = is_ptr_add && sel == `PTR_SEL_RETURN; // [RULE1]
    assign move_dst = instr_word[11:0]; // [RULE12] [RULE13]
    // 12-bit wrap keeps the sum inside the full data space
    assign move_src = r.ptr2 + {5'h00, off7}; // [RULE11] [RULE13]
    // 21-bit wrap, like the core's own program counter
    assign call_ret_addr = pc + `PC_STEP; // [RULE6]
    assign call_target = {pc_upper_latch, pc_high_latch, working_register}; // [RULE7]

    always_comb begin
        op = op_none;
        if (take_ret) begin
            op = op_ret;
        end else if (is_ptr_add) begin
            op = op_add;
        end else if (is_call) begin
            op = op_call;
        end else if (is_move) begin
            op = op_move;
        end
    end

    assign ptr_now[0] = r.ptr0;
    assign ptr_now[1] = r.ptr1;
    assign ptr_now[2] = r.ptr2;

    // one adder per pointer; select 11 folds onto pointer 2
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ptr
            if (g == 2) begin : g_frame
                assign ptr_hit[g] = is_ptr_add && sel[1]; // [RULE1]
            end else begin : g_plain
                assign ptr_hit[g] = is_ptr_add && sel == 2'(g); // [RULE1]
            end
            assign ptr_sum[g] = ptr_now[g] + {6'h00, lit6}; // [RULE2]
        end
    endgenerate

    always_comb begin
        next_r = r;
        next_r.pc_load = 1'b0;
        next_r.push = 1'b0;
        next_r.pop = 1'b0;
        next_r.rd_en = 1'b0;
        next_r.wr_en = 1'b0;
        next_r.nop = 1'b0;
        // memory answers one edge after the strobe, so capture then
        next_r.rd_wait = r.rd_en; // [RULE18]
        if (r.rd_wait) begin
            next_r.move_byte = data_rd; // [RULE18]
        end
        if (phase4) begin
            // decode and execute land on the phase-four edge; read capture and early address do not
            case (r.st)
                st_decode: begin
                    case (op)
                        op_add, op_ret: begin
                            if (ptr_hit[0]) begin
                                next_r.ptr0 = ptr_sum[0]; // [RULE2]
                            end
                            if (ptr_hit[1]) begin
                                next_r.ptr1 = ptr_sum[1]; // [RULE2]
                            end
                            if (ptr_hit[2]) begin
                                next_r.ptr2 = ptr_sum[2]; // [RULE2]
                            end
                            if (op == op_ret) begin
                                next_r.pc_load = 1'b1; // [RULE3]
                                next_r.pc_val = return_stack_top; // [RULE3]
                                next_r.pop = 1'b1; // [RULE3]
                                next_r.st = st_return_nop; // [RULE4]
                            end
                        end
                        op_call: begin
                            next_r.push = 1'b1; // [RULE6]
                            next_r.push_val = call_ret_addr; // [RULE6]
                            // working register only read, never written back
                            next_r.pc_load = 1'b1; // [RULE7] [RULE9]
                            next_r.pc_val = call_target; // [RULE7]
                            next_r.st = st_call_nop; // [RULE8]
                        end
                        op_move: begin
                            // skipped read leaves the preloaded zero in place
                            next_r.rd_en = !src_is_indirect; // [RULE15] [RULE18]
                            next_r.move_byte = `INDIRECT_READ_VALUE; // [RULE15]
                            next_r.addr = move_src; // [RULE11]
                            next_r.st = st_move_second;
                        end
                        default: begin
                            next_r.st = st_decode;
                        end
                    endcase
                end
                st_return_nop: begin
                    next_r.nop = 1'b1; // [RULE4]
                    next_r.st = st_decode;
                end
                st_call_nop: begin
                    next_r.nop = 1'b1; // [RULE8]
                    next_r.st = st_decode;
                end
                st_move_second: begin
                    // second word: destination only, no other data access between
                    if (is_second) begin // [RULE10]
                        next_r.wr_en = 1'b1; // [RULE18]
                        next_r.addr = move_dst; // [RULE12] [RULE13]
                        next_r.wr_data = r.move_byte; // [RULE12]
                    end
                    next_r.st = st_decode;
                end
                default: begin
                    next_r.st = st_decode;
                end
            endcase
        end else if (r.st == st_decode && op == op_move) begin
            // address settles early so the indirect flag is valid at phase four
            next_r.addr = move_src; // [RULE11] [RULE15]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '{st: st_decode, ptr0: `PTR_RESET, ptr1: `PTR_RESET, ptr2: `PTR_RESET,
                   move_byte: `INDIRECT_READ_VALUE, pc_val: `PC_RESET, push_val: `PC_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign pointer_register0 = r.ptr0;
    assign pointer_register1 = r.ptr1;
    assign stack_frame_pointer = r.ptr2;
    assign pc_load = r.pc_load;
    assign pc_load_value = r.pc_val;
    assign stack_push = r.push;
    assign stack_push_value = r.push_val;
    assign stack_pop = r.pop;
    assign data_rd_en = r.rd_en;
    assign data_wr_en = r.wr_en;
    assign data_addr = r.addr;
    assign data_wr = r.wr_data;
    assign force_nop = r.nop;
    // tells the core to keep flags, working register and bank select untouched
    assign status_write_block = op != op_none || r.st != st_decode; // [RULE17] [RULE9]
endmodule : extended_pointer_call_move_ops

// ===== verification/ext_ops_sva.sv
// port assertions for the extended operation decoder
// assumes a phase4 edge every fourth core_clk
module ext_ops_sva (
    input wire logic core_clk, rst, extension_enable_bit, phase4, pc_load, stack_push, stack_pop,
    input wire logic data_rd_en, data_wr_en, force_nop, status_write_block, src_is_indirect,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] pc, return_stack_top, pc_load_value, stack_push_value,
    input wire logic [7:0] working_register, pc_high_latch,
    input wire logic [4:0] pc_upper_latch,
    input wire logic [11:0] stack_frame_pointer, data_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic go = phase4 && extension_enable_bit;
    wire logic ret = go && instr_word[15:6] == 10'h3A3;
    wire logic call = go && instr_word == 16'h0014;
    wire logic mv = go && instr_word[15:7] == 9'h1D6;
    a_ret_pops: assert property (ret |=> stack_pop && pc_load && pc_load_value == $past(return_stack_top))
        else $error("return not taken");
    a_ret_frame: assert property (ret |=> stack_frame_pointer == $past(stack_frame_pointer) + {6'h00, 6'($past(instr_word))})
        else $error("frame pointer sum");
    a_ret_nop: assert property (ret |=> !force_nop[*4] ##1 force_nop)
        else $error("return nop cycle");
    a_call_push: assert property (call |=> stack_push && stack_push_value == $past(pc) + 21'h0_0002)
        else $error("call push");
    a_call_load: assert property (call |=> pc_load && pc_load_value == {$past(pc_upper_latch), $past(pc_high_latch), $past(working_register)})
        else $error("call target");
    a_call_nop: assert property (call |=> !force_nop[*4] ##1 force_nop)
        else $error("call nop cycle");
    a_move_read: assert property (mv |=> data_rd_en == !$past(src_is_indirect) && !data_wr_en && data_addr == $past(stack_frame_pointer) + {5'h00, 7'($past(instr_word))})
        else $error("move source");
    a_move_write: assert property (mv |=> ##1 (!data_rd_en && !data_wr_en)[*3] ##1 data_wr_en && data_addr == 12'($past(instr_word)))
        else $error("move destination");
    a_off_quiet: assert property (phase4 && !extension_enable_bit |=> !(pc_load || stack_push || stack_pop || data_rd_en))
        else $error("decoded while disabled");
    a_flags_held: assert property (ret || call || mv |-> status_write_block)
        else $error("status writes open");
endmodule : ext_ops_sva
bind extended_pointer_call_move_ops ext_ops_sva i_ext_ops_sva (.*);

// ===== verification/core_model.sv
// behavioural pc, return stack and data memory
// assumes one-cycle pulses from the decoder
module core_model (
    input wire logic core_clk, rst, pc_load, stack_push, stack_pop, data_rd_en, data_wr_en,
    input wire logic [20:0] pc_load_value, stack_push_value,
    input wire logic [11:0] data_addr,
    input wire logic [7:0] data_wr,
    output logic [20:0] pc, return_stack_top,
    output logic [7:0] data_rd,
    output logic src_is_indirect
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [20:0] stk [0:31];
    logic [7:0] mem [0:4095];
    logic [4:0] sp;
    logic [11:0] ind_addr = 12'hFFF;
    assign return_stack_top = stk[sp];
    assign src_is_indirect = data_addr == ind_addr;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc <= 21'h0_0100;
            sp <= 5'h00;
            data_rd <= 8'h00;
        end else begin
            if (pc_load) pc <= pc_load_value;
            if (stack_push) stk[sp + 5'h01] <= stack_push_value;
            sp <= sp + 5'(stack_push) - 5'(stack_pop);
            // read data inverts every cycle once the read is over
            data_rd <= data_rd_en ? mem[data_addr] : ~data_rd;
            if (data_wr_en) mem[data_addr] <= data_wr;
        end
    end
endmodule : core_model

// ===== verification/extended_pointer_call_move_ops_test.sv
// self-checking bench for the extended operation decoder
// assumes core_model as far side; phase4 every fourth core_clk
module extended_pointer_call_move_ops_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst = 1, extension_enable_bit = 1, phase4 = 0, pc_load, stack_push, stack_pop;
    logic data_rd_en, data_wr_en, force_nop, status_write_block, src_is_indirect;
    logic [15:0] instr_word = 16'h0000;
    logic [20:0] pc, pc_load_value, stack_push_value, return_stack_top;
    logic [7:0] working_register = 8'hA6, pc_high_latch = 8'h10, data_rd, data_wr;
    logic [4:0] pc_upper_latch = 5'h01;
    logic [11:0] pointer_register0, pointer_register1, stack_frame_pointer, data_addr;
    logic [11:0] ep [0:2] = '{12'h000, 12'h000, 12'h000};
    logic [1:0] cnt = 2'h0;
    int n_mismatch = 0, cmp_count = 0;
    extended_pointer_call_move_ops i_extended_pointer_call_move_ops (.*);
    core_model i_core_model (.*);
    always #12.5 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        cnt <= cnt + 2'h1;
        phase4 <= cnt == 2'h2;
    end
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // word stands a whole instruction cycle, just past one phase-four edge to the next
    task automatic issue(input logic [15:0] w);
        while (cnt != 2'h3) @(negedge core_clk);
        instr_word = w;
        repeat (4) @(negedge core_clk);
    endtask : issue
    task automatic t_add();
        for (int i = 0; i < 198; i++) begin
            issue({8'hE8, 2'(i % 3), 6'h3F});
            ep[i % 3] = ep[i % 3] + 12'h03F;
        end
        chk("ptr0", 21'(ep[0]), 21'(pointer_register0));
        chk("ptr1", 21'(ep[1]), 21'(pointer_register1));
        chk("ptr2", 21'(ep[2]), 21'(stack_frame_pointer));
    endtask : t_add
    task automatic t_call_ret();
        logic [20:0] back;
        back = pc + 21'h0_0002;
        issue(16'h0014);
        issue(16'h0000);
        chk("call pc", {5'h01, 8'h10, 8'hA6}, pc);
        chk("stack top", back, return_stack_top);
        issue({8'hE8, 2'h3, 6'h21});
        issue(16'h0000);
        ep[2] = ep[2] + 12'h021;
        chk("return pc", back, pc);
        chk("ptr2", 21'(ep[2]), 21'(stack_frame_pointer));
    endtask : t_call_ret
    // destinations kept off pc low and stack top bytes
    task automatic t_move(input logic [6:0] z, input logic [11:0] dst, input logic [7:0] b, input logic ind);
        logic [11:0] src;
        src = stack_frame_pointer + 12'(z);
        i_core_model.mem[src] = b;
        i_core_model.ind_addr = ind ? src : ~src;
        issue({8'hEB, 1'b0, z});
        issue({4'hF, dst});
        @(negedge core_clk);
        chk("moved byte", ind ? 21'h0_0000 : 21'(b), 21'(i_core_model.mem[dst]));
    endtask : t_move
    task automatic t_off();
        logic [20:0] was;
        was = pc;
        extension_enable_bit = 0;
        issue(16'h0014);
        issue({8'hE8, 8'h3F});
        instr_word = 16'h0000;
        extension_enable_bit = 1;
        chk("pc disabled", was, pc);
        chk("ptr0 disabled", 21'(ep[0]), 21'(pointer_register0));
    endtask : t_off
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(negedge core_clk);
        rst = 0;
        t_add();
        t_call_ret();
        t_move(7'h7F, 12'hFFF, 8'h3C, 1'b0);
        t_move(7'h00, 12'h000, 8'hC3, 1'b1);
        t_off();
        finish_test();
    end
    // run needs about 850 cycles
    initial begin
        #50us;
        n_mismatch++;
        finish_test();
    end
endmodule : extended_pointer_call_move_ops_test
